// [inc/ibt_pkg.sv]
// Shared constants, types and state layout for the byte transfer engine
package ibt_pkg;

  localparam int unsigned DATA_W      = 8;      // Byte width on the wire
  localparam logic [3:0]  BIT_FIRST   = 4'h0;   // First bit index
  localparam logic [3:0]  BIT_LAST    = 4'h7;   // Eighth bit (read/write or LSB)
  localparam logic [3:0]  BIT_ACK     = 4'h8;   // Ninth clock, acknowledge slot
  localparam logic [7:0]  BYTE_RESET  = 8'h00;  // Reset value of byte holders
  localparam logic [7:0]  BAUD_ZERO   = 8'h00;  // Generator terminal count
  localparam logic        LINE_REL    = 1'b0;   // Enable low: line released
  localparam logic        LINE_PULL   = 1'b1;   // Enable high: line pulled low
  localparam logic        PIN_IDLE    = 1'b1;   // Bus idle level for syncs

  // Engine states
  typedef enum logic [2:0] {
    IBT_IDLE    = 3'b000,  // Waiting for a command
    IBT_HOLD    = 3'b001,  // Start hold time after a start condition
    IBT_TX_LOW  = 3'b010,  // Transmit, clock low phase
    IBT_TX_WAIT = 3'b011,  // Transmit, clock released, waiting for high
    IBT_TX_HIGH = 3'b100,  // Transmit, clock high phase
    IBT_RX_LOW  = 3'b101,  // Receive, clock low phase
    IBT_RX_WAIT = 3'b110,  // Receive, clock released, waiting for high
    IBT_RX_HIGH = 3'b111   // Receive, clock high phase
  } ibt_state_t;

  // Pin level pair after synchronisation
  typedef struct packed {
    logic scl;  // Clock line level
    logic sda;  // Data line level
  } ibt_pins_t;

  // Software-visible status flags
  typedef struct packed {
    logic buffer_full_flag;       // Buffer holds unread / unsent byte
    logic write_collision_flag;   // Buffer write refused
    logic receive_overflow_flag;  // Byte arrived onto a full buffer
    logic ack_status_bit;         // 1 when slave did not acknowledge
    logic port_interrupt_flag;    // Completion event
    logic receive_enable_bit;     // Reception in progress
  } ibt_flags_t;

  // Whole state of the main engine
  typedef struct packed {
    ibt_pins_t  sync1;            // First synchroniser stage
    ibt_pins_t  sync2;            // Second synchroniser stage
    ibt_state_t state;            // Engine state
    logic [3:0] bit_cnt;          // Bit index within the byte
    logic [7:0] byte_shift;       // Shift register
    logic [7:0] transfer_buffer;  // Buffer seen by software
    ibt_flags_t flags;            // Status flags
    logic       scl_oe;           // Clock pull-down enable
    logic       sda_oe;           // Data pull-down enable
    logic       scl_park;         // Clock kept low between bytes
  } ibt_core_t;

  // Whole state of the baud generator
  typedef struct packed {
    logic [7:0] count;            // Down counter
    logic       tick;             // Rollover pulse
  } ibt_baud_t;

endpackage

// [logic/ibt_baud_gen.sv]
// Baud rate generator: reloadable down counter with rollover pulse
`timescale 1ns/1ps
module ibt_baud_gen
  import ibt_pkg::*;
(
  input  wire logic       core_clk,     // System clock
  input  wire logic       resetn,       // Async reset, active low
  input  wire logic       run,          // Count while high, reload while low
  input  wire logic [7:0] reload,       // Baud reload value
  output logic            tick          // One-cycle rollover pulse
);

  ibt_baud_t st_reg;   // Registered state
  ibt_baud_t st_next;  // Next state

  // Counter: a stopped generator always restarts a full period
  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.count = reload;  // Reload on every period start
    end else if (st_reg.count == BAUD_ZERO) begin
      st_next.count = reload;  // Rollover reloads too
      st_next.tick  = 1'b1;
    end else begin
      st_next.count = st_reg.count - 8'h01;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{count: BAUD_ZERO, tick: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;  // Straight from a flip-flop

endmodule

// [logic/ibt_byte_engine.sv]
// Master byte transmit/receive engine for a two-wire serial port
//
// Function
// - Buffer write sets full flag, starts shifting
// - Change data after fall; low then high period
// - Data valid before clock release, held stable
// - Eighth fall clears full flag, releases data
// - Ninth clock captures slave acknowledge level
// - After ninth clock: interrupt, clock held low
// - Address: seven bits then read/write bit
// - Write while sending sets collision, ignored
// - Wait start hold time after start
// - Interrupt after stop or restart completes
// - Receive enable honoured only when idle
// - Receive: clock toggles per rollover, sample
// - Eighth receive fall: buffer load, flags, halt
// - Software buffer read clears full flag, except while receiving
// - Byte onto full buffer sets overflow
// - Write while receiving sets collision, ignored
// - Generator reloads baud setting each period
// - Generator waits until clock sampled high
`timescale 1ns/1ps
module ibt_byte_engine
  import ibt_pkg::*;
(
  input  wire logic       core_clk,               // System clock, 50 MHz
  input  wire logic       resetn,                 // Async reset, active low
  input  wire logic       buf_wr,                 // Software buffer write pulse
  input  wire logic [7:0] buf_wr_data,            // Byte written by software
  input  wire logic       buf_rd,                 // Software buffer read pulse
  output logic      [7:0] transfer_buffer,        // Buffer contents
  input  wire logic       receive_enable_set,     // Receive request pulse
  input  wire logic       write_collision_flag_clear,             // Clear collision flag
  input  wire logic       overflow_clear,         // Clear overflow flag
  input  wire logic       irq_clear,              // Clear interrupt flag
  input  wire logic [7:0] baud_reload_register,   // Baud reload value
  input  wire logic       sequence_busy,          // Start/stop/restart/ack active
  input  wire logic       start_done,             // Start condition finished
  input  wire logic       condition_done,         // Stop or restart finished
  output logic            buffer_full_flag,       // Buffer full
  output logic            write_collision_flag,   // Write collision
  output logic            receive_overflow_flag,  // Receive overflow
  output logic            ack_status_bit,         // Slave did not acknowledge
  output logic            port_interrupt_flag,    // Completion event
  output logic            receive_enable_bit,     // Reception in progress
  output logic            engine_busy,            // Engine pulls the clock low
  input  wire logic       serial_clock_line_in,   // Clock pin level
  output logic            serial_clock_line_out,  // Clock pin drive value
  output logic            serial_clock_line_oe,   // Clock pull-down enable
  input  wire logic       serial_data_line_in,    // Data pin level
  output logic            serial_data_line_out,   // Data pin drive value
  output logic            serial_data_line_oe     // Data pull-down enable
);

  ibt_core_t st_reg;   // Registered state
  ibt_core_t st_next;  // Next state
  logic      brg_run;  // Generator counting
  logic      brg_tick; // Generator rollover

  // Reset image of the whole state
  localparam ibt_core_t CORE_RESET = '{
    sync1:           '{scl: PIN_IDLE, sda: PIN_IDLE},
    sync2:           '{scl: PIN_IDLE, sda: PIN_IDLE},
    state:           IBT_IDLE,
    bit_cnt:         BIT_FIRST,
    byte_shift:      BYTE_RESET,
    transfer_buffer: BYTE_RESET,
    flags:           '0,
    scl_oe:          LINE_REL,
    sda_oe:          LINE_REL,
    scl_park:        1'b0
  };

  // Pull-down enable for one data bit: a one is a released line
  function automatic logic bit_drive(input logic [7:0] b);
    bit_drive = b[7] ? LINE_REL : LINE_PULL;
  endfunction

  // Generator runs in timed phases only; in the wait phases it stands
  // still so a slave holding the clock low stretches the low time
  always_comb begin
    case (st_reg.state)
      IBT_HOLD,
      IBT_TX_LOW,
      IBT_TX_HIGH,
      IBT_RX_LOW,
      IBT_RX_HIGH: brg_run = 1'b1;
      default:     brg_run = 1'b0;
    endcase
  end

  // Rollover timing source
  ibt_baud_gen u_baud (
    .core_clk (core_clk),
    .resetn   (resetn),
    .run      (brg_run),
    .reload   (baud_reload_register),
    .tick     (brg_tick)
  );

  // Next-state logic for the whole engine
  always_comb begin
    st_next       = st_reg;
    st_next.sync1 = '{scl: serial_clock_line_in, sda: serial_data_line_in};
    st_next.sync2 = st_reg.sync1;

    // Software clears first; hardware sets below win over them
    if (write_collision_flag_clear) begin
      st_next.flags.write_collision_flag = 1'b0;
    end
    if (overflow_clear) begin
      st_next.flags.receive_overflow_flag = 1'b0;
    end
    if (irq_clear) begin
      st_next.flags.port_interrupt_flag = 1'b0;
    end
    // Read side effect; a byte landing this cycle sets it again
    if (buf_rd && !st_reg.flags.receive_enable_bit) begin
      st_next.flags.buffer_full_flag = 1'b0;
    end

    // Neighbouring sequences own the clock line while they run
    if (sequence_busy) begin
      st_next.scl_park = 1'b0;
      st_next.scl_oe   = LINE_REL;
    end

    // Stop or restart finished: completion event
    if (condition_done) begin
      st_next.flags.port_interrupt_flag = 1'b1;
    end

    case (st_reg.state)
      // Waiting for software
      IBT_IDLE: begin
        // Parked clock stays low until a byte or a sequence moves it
        if (st_reg.scl_park && !sequence_busy) begin
          st_next.scl_oe = LINE_PULL;
        end
        if (start_done) begin
          st_next.state = IBT_HOLD;
        end else if (buf_wr && !sequence_busy) begin
          // Address or data byte; first bit goes out at once
          st_next.transfer_buffer        = buf_wr_data;
          st_next.byte_shift             = buf_wr_data;
          st_next.flags.buffer_full_flag = 1'b1;
          st_next.bit_cnt                = BIT_FIRST;
          st_next.scl_oe                 = LINE_PULL;
          st_next.sda_oe                 = bit_drive(buf_wr_data);
          st_next.state                  = IBT_TX_LOW;
        end else if (receive_enable_set && !sequence_busy) begin
          st_next.flags.receive_enable_bit = 1'b1;
          st_next.bit_cnt                  = BIT_FIRST;
          st_next.scl_oe                   = LINE_PULL;
          st_next.sda_oe                   = LINE_REL;  // Slave drives
          st_next.state                    = IBT_RX_LOW;
        end
        // A write while a sequence runs or a start ends is a collision
        if (buf_wr && (sequence_busy || start_done)) begin
          st_next.flags.write_collision_flag = 1'b1;
        end
      end

      // One generator period of hold after the start
      IBT_HOLD: begin
        if (brg_tick) begin
          st_next.state = IBT_IDLE;
        end
        if (buf_wr) begin
          st_next.flags.write_collision_flag = 1'b1;
        end
      end

      // Clock low, data already set up
      IBT_TX_LOW: begin
        if (brg_tick) begin
          st_next.scl_oe = LINE_REL;  // Data stable before release
          st_next.state  = IBT_TX_WAIT;
        end
        if (buf_wr) begin
          st_next.flags.write_collision_flag = 1'b1;
        end
      end

      // Clock released, wait until really high
      IBT_TX_WAIT: begin
        if (st_reg.sync2.scl) begin
          st_next.state = IBT_TX_HIGH;
          if (st_reg.bit_cnt == BIT_ACK) begin
            st_next.flags.ack_status_bit = st_reg.sync2.sda;
          end
        end
        if (buf_wr) begin
          st_next.flags.write_collision_flag = 1'b1;
        end
      end

      // Clock high for one period, then falling edge
      IBT_TX_HIGH: begin
        if (brg_tick) begin
          st_next.scl_oe     = LINE_PULL;
          st_next.bit_cnt    = st_reg.bit_cnt + 4'h1;
          st_next.byte_shift = {st_reg.byte_shift[6:0], 1'b0};
          if (st_reg.bit_cnt == BIT_ACK) begin
            // Ninth fall: hold clock low, keep data as it is
            st_next.flags.port_interrupt_flag = 1'b1;
            st_next.scl_park                  = 1'b1;
            st_next.state                     = IBT_IDLE;
          end else if (st_reg.bit_cnt == BIT_LAST) begin
            st_next.flags.buffer_full_flag = 1'b0;
            st_next.sda_oe                 = LINE_REL;
            st_next.state                  = IBT_TX_LOW;
          end else begin
            // Next bit changes only after this fall
            st_next.sda_oe = bit_drive({st_reg.byte_shift[6:0], 1'b0});
            st_next.state  = IBT_TX_LOW;
          end
        end
        if (buf_wr) begin
          st_next.flags.write_collision_flag = 1'b1;
        end
      end

      // Receive: clock low for one rollover
      IBT_RX_LOW: begin
        if (brg_tick) begin
          st_next.scl_oe = LINE_REL;
          st_next.state  = IBT_RX_WAIT;
        end
        if (buf_wr) begin
          st_next.flags.write_collision_flag = 1'b1;
        end
      end

      // Receive: stretched clock holds the generator
      IBT_RX_WAIT: begin
        if (st_reg.sync2.scl) begin
          st_next.state = IBT_RX_HIGH;
        end
        if (buf_wr) begin
          st_next.flags.write_collision_flag = 1'b1;
        end
      end

      // Receive: sample at the end of the high phase, then fall
      IBT_RX_HIGH: begin
        if (brg_tick) begin
          st_next.scl_oe     = LINE_PULL;
          st_next.byte_shift = {st_reg.byte_shift[6:0], st_reg.sync2.sda};
          st_next.bit_cnt    = st_reg.bit_cnt + 4'h1;
          st_next.state      = IBT_RX_LOW;
          if (st_reg.bit_cnt == BIT_LAST) begin
            st_next.flags.receive_enable_bit  = 1'b0;
            st_next.transfer_buffer = {st_reg.byte_shift[6:0],
                                       st_reg.sync2.sda};
            st_next.flags.buffer_full_flag    = 1'b1;
            st_next.flags.port_interrupt_flag = 1'b1;
            st_next.scl_park                  = 1'b1;
            st_next.state                     = IBT_IDLE;
            // Previous byte never read: report overflow
            if (st_reg.flags.buffer_full_flag) begin
              st_next.flags.receive_overflow_flag = 1'b1;
            end
          end
        end
        if (buf_wr) begin
          st_next.flags.write_collision_flag = 1'b1;
        end
      end

      default: begin
        st_next.state = IBT_IDLE;
      end
    endcase
  end

  // State register; async reset loads constants only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= CORE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs, all taken from the state register
  assign transfer_buffer       = st_reg.transfer_buffer;
  assign buffer_full_flag      = st_reg.flags.buffer_full_flag;
  assign write_collision_flag  = st_reg.flags.write_collision_flag;
  assign receive_overflow_flag = st_reg.flags.receive_overflow_flag;
  assign ack_status_bit        = st_reg.flags.ack_status_bit;
  assign port_interrupt_flag   = st_reg.flags.port_interrupt_flag;
  assign receive_enable_bit    = st_reg.flags.receive_enable_bit;
  assign engine_busy           = st_reg.scl_oe;
  // Lines are pulled low or released, never driven high
  assign serial_clock_line_out = st_reg.sync2.scl & 1'b0;
  assign serial_data_line_out  = st_reg.sync2.sda & 1'b0;
  assign serial_clock_line_oe  = st_reg.scl_oe;
  assign serial_data_line_oe   = st_reg.sda_oe;

endmodule

// [test/ibt_checker.sv]
// Port-level assertions for the byte transfer engine
`timescale 1ns/1ps
module ibt_checker
  import ibt_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       buf_wr,
  input wire logic [7:0] buf_wr_data,
  input wire logic       buf_rd,
  input wire logic       receive_enable_set,
  input wire logic [7:0] baud_reload_register,
  input wire logic       sequence_busy,
  input wire logic       condition_done,
  input wire logic [7:0] transfer_buffer,
  input wire logic       buffer_full_flag,
  input wire logic       write_collision_flag,
  input wire logic       receive_overflow_flag,
  input wire logic       port_interrupt_flag,
  input wire logic       receive_enable_bit,
  input wire logic       serial_clock_line_in,
  input wire logic       serial_clock_line_out,
  input wire logic       serial_clock_line_oe,
  input wire logic       serial_data_line_out,
  input wire logic       serial_data_line_oe
);
  logic [15:0] low_cnt;   // Cycles with clock pulled low
  logic [15:0] high_cnt;  // Cycles with clock released and high
  logic [15:0] period;    // Baud reload value, one cycle less than a generator period

  assign period = {8'h00, baud_reload_register};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Phase length counters; a stretched phase only grows them
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt  <= 16'h0000;
      high_cnt <= 16'h0000;
    end else begin
      low_cnt  <= serial_clock_line_oe ? low_cnt + 16'h0001 : 16'h0000;
      high_cnt <= (!serial_clock_line_oe && serial_clock_line_in) ?
                  high_cnt + 16'h0001 : 16'h0000;
    end
  end

  property p_low_only;
    !serial_clock_line_out && !serial_data_line_out;
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("line driven high");
  property p_accept;
    buf_wr && !write_collision_flag ##1 !write_collision_flag |->
      buffer_full_flag && serial_clock_line_oe &&
      transfer_buffer == $past(buf_wr_data);
  endproperty
  a_accept: assert property (p_accept)
    else $error("accepted write not started");
  property p_rx_write_collision_flag;
    buf_wr && receive_enable_bit |=>
      write_collision_flag && $stable(transfer_buffer);
  endproperty
  a_rx_write_collision_flag: assert property (p_rx_write_collision_flag)
    else $error("write during receive not refused");
  property p_tx_end;
    $fell(buffer_full_flag) && !$past(buf_rd) && !receive_enable_bit |->
      !serial_data_line_oe && serial_clock_line_oe;
  endproperty
  a_tx_end: assert property (p_tx_end)
    else $error("data not released at eighth fall");
  property p_park;
    $rose(port_interrupt_flag) && !$past(condition_done) |->
      serial_clock_line_oe [*2];
  endproperty
  a_park: assert property (p_park)
    else $error("clock not held low after byte");
  property p_rx_done;
    $fell(receive_enable_bit) |->
      buffer_full_flag && port_interrupt_flag && serial_clock_line_oe;
  endproperty
  a_rx_done: assert property (p_rx_done)
    else $error("receive completion flags wrong");
  property p_ovf;
    $fell(receive_enable_bit) && $past(buffer_full_flag) |->
      receive_overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow not flagged");
  property p_rx_busy;
    receive_enable_set && sequence_busy && !receive_enable_bit |=>
      !receive_enable_bit;
  endproperty
  a_rx_busy: assert property (p_rx_busy)
    else $error("receive request taken while busy");
  property p_low_len;
    $fell(serial_clock_line_oe) && !sequence_busy |-> low_cnt > period;
  endproperty
  a_low_len: assert property (p_low_len)
    else $error("clock low phase too short");
  property p_high_len;
    $rose(serial_clock_line_oe) && !$past(buf_wr) && !sequence_busy &&
      !$past(receive_enable_set) && !$past(sequence_busy) |->
      high_cnt > period;
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("clock high phase too short");
  property p_stable;
    !serial_clock_line_oe && serial_clock_line_in && !sequence_busy &&
      $past(serial_clock_line_in) |-> $stable(serial_data_line_oe);
  endproperty
  a_stable: assert property (p_stable)
    else $error("data moved while clock high");
endmodule

// [test/ibt_slave_model.sv]
// Behavioural two-wire slave facing the byte engine
`timescale 1ns/1ps
module ibt_slave_model
  import ibt_pkg::*;
(
  input  wire logic       core_clk,  // System clock for stretching
  input  wire logic       scl,       // Resolved clock line
  input  wire logic       sda,       // Resolved data line
  input  wire logic       start,     // Frame restart, rising edge
  input  wire logic       send,      // High: slave sends tx_byte
  input  wire logic       ack_n,     // Level given in the ack slot
  input  wire logic [7:0] tx_byte,   // Byte sent to the master
  input  wire logic [7:0] stretch,   // Low hold after each fall
  output logic            scl_pull,  // Pulls clock low
  output logic            sda_pull,  // Pulls data low
  output logic      [7:0] rx_byte    // Byte shifted in
);
  int         nbit;      // Rising clock edges since restart
  logic [7:0] hold_cnt;  // Stretch countdown
  logic       scl_q;     // Clock line one cycle ago

  initial begin
    nbit = 0;
    sda_pull = 1'b0;
    hold_cnt = 8'h00;
    scl_q = 1'b1;
    rx_byte = 8'h00;
  end
  // Sample on the first eight rising edges, first bit is the top one
  always @(posedge scl or posedge start) begin
    if (start) begin
      nbit <= 0;
    end else begin
      if (nbit < 8) rx_byte <= {rx_byte[6:0], sda};
      nbit <= nbit + 1;
    end
  end
  // Data only moves after a fall; released lines float to the pull-up
  always @(negedge scl or posedge start) begin
    if (start) sda_pull <= send && !tx_byte[7];
    else if (send) sda_pull <= nbit < 8 && !tx_byte[7 - nbit];
    else sda_pull <= nbit == 8 && !ack_n;
  end
  // Stretch the low phase, as a slow slave would
  always @(posedge core_clk) begin
    scl_q <= scl;
    if (scl_q && !scl) hold_cnt <= stretch;
    else if (hold_cnt != 8'h00) hold_cnt <= hold_cnt - 8'h01;
  end
  assign scl_pull = hold_cnt != 8'h00;
endmodule

// [test/test_ibt_byte_engine.sv]
// Self-checking bench for the byte transfer engine
`timescale 1ns/1ps
module test_ibt_byte_engine;
  import ibt_pkg::*;
  logic core_clk, resetn, buf_wr, buf_rd, receive_enable_set, write_collision_flag_clear;
  logic overflow_clear, irq_clear, sequence_busy, start_done;
  logic condition_done, engine_busy, buffer_full_flag, write_collision_flag;
  logic receive_overflow_flag, ack_status_bit, port_interrupt_flag;
  logic receive_enable_bit, serial_clock_line_in, serial_clock_line_out;
  logic serial_clock_line_oe, serial_data_line_in, serial_data_line_out;
  logic serial_data_line_oe, s_start, s_send, s_ack_n, s_scl, s_sda;
  logic [7:0] buf_wr_data, baud_reload_register, transfer_buffer;
  logic [7:0] s_tx, s_stretch, s_rx;
  int         bad_count = 0;  // Mismatches seen
  int         n_checks = 0;   // Comparisons made

  // Open-drain wires with pull-ups
  assign serial_clock_line_in = !(serial_clock_line_oe || s_scl);
  assign serial_data_line_in  = !(serial_data_line_oe || s_sda);
  ibt_byte_engine u_dut (.core_clk, .resetn, .buf_wr, .buf_wr_data,
    .buf_rd, .transfer_buffer, .receive_enable_set, .write_collision_flag_clear,
    .overflow_clear, .irq_clear, .baud_reload_register, .sequence_busy,
    .start_done, .condition_done, .buffer_full_flag, .write_collision_flag,
    .receive_overflow_flag, .ack_status_bit, .port_interrupt_flag,
    .receive_enable_bit, .engine_busy, .serial_clock_line_in,
    .serial_clock_line_out, .serial_clock_line_oe, .serial_data_line_in,
    .serial_data_line_out, .serial_data_line_oe);
  ibt_slave_model u_slave (.core_clk, .scl(serial_clock_line_in),
    .sda(serial_data_line_in), .start(s_start), .send(s_send),
    .ack_n(s_ack_n), .tx_byte(s_tx), .stretch(s_stretch),
    .scl_pull(s_scl), .sda_pull(s_sda), .rx_byte(s_rx));

  always #10 core_clk = ~core_clk;
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge core_clk) s = 1'b1;
    @(negedge core_clk) s = 1'b0;
  endtask
  task automatic wr(logic [7:0] d);
    @(negedge core_clk);
    buf_wr_data = d;
    buf_wr = 1'b1;
    @(negedge core_clk) buf_wr = 1'b0;
  endtask
  // Bounded wait for completion, then acknowledge it
  task automatic wait_irq();
    int i;
    i = 0;
    while (port_interrupt_flag !== 1'b1 && i < 3000) begin
      @(negedge core_clk);
      i++;
    end
    chk("irq", 8'h01, 8'(port_interrupt_flag));
    pulse(irq_clear);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog: all tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    summarize();
  end
  initial begin
    {core_clk, resetn, buf_wr, buf_rd, receive_enable_set} = 5'h00;
    {write_collision_flag_clear, overflow_clear, irq_clear, sequence_busy} = 4'h0;
    {start_done, condition_done, s_start, s_send, s_ack_n} = 5'h00;
    {buf_wr_data, s_tx, s_stretch} = 24'h000000;
    baud_reload_register = 8'h03;
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    chk("flags", 8'h00, 8'({buffer_full_flag, write_collision_flag,
      receive_overflow_flag, port_interrupt_flag, receive_enable_bit}));
    $display("test reset done");
    // Address write: refused in hold, refused while shifting
    pulse(start_done);
    wr(8'h77);
    chk("write_collision_flag", 8'h01, 8'(write_collision_flag));
    pulse(write_collision_flag_clear);
    repeat (20) @(negedge core_clk);
    pulse(s_start);
    wr(8'ha4);
    chk("bf", 8'h01, 8'(buffer_full_flag));
    wr(8'h11);
    chk("write_collision_flag", 8'h01, 8'(write_collision_flag));
    chk("buf", 8'ha4, transfer_buffer);
    pulse(write_collision_flag_clear);
    pulse(receive_enable_set);
    chk("receive_enable_bit", 8'h00, 8'(receive_enable_bit));
    wait_irq();
    chk("addr", 8'ha4, s_rx);
    chk("ack", 8'h00, 8'(ack_status_bit));
    chk("bf", 8'h00, 8'(buffer_full_flag));
    chk("park", 8'h01, 8'(serial_clock_line_oe));
    chk("busy", 8'h01, 8'(engine_busy));
    $display("test address done");
    // Data byte refused by a slow slave
    {s_ack_n, s_stretch} = {1'b1, 8'h0a};
    pulse(s_start);
    wr(8'h5b);
    wait_irq();
    chk("data", 8'h5b, s_rx);
    chk("ack", 8'h01, 8'(ack_status_bit));
    $display("test data done");
    // Read address, then two bytes without reading between
    {s_ack_n, s_stretch} = {1'b0, 8'h00};
    pulse(s_start);
    wr(8'ha5);
    wait_irq();
    {s_send, s_tx} = {1'b1, 8'hc3};
    pulse(s_start);
    pulse(receive_enable_set);
    chk("receive_enable_bit", 8'h01, 8'(receive_enable_bit));
    wr(8'h00);
    chk("write_collision_flag", 8'h01, 8'(write_collision_flag));
    chk("buf", 8'ha5, transfer_buffer);
    wait_irq();
    chk("rx", 8'hc3, transfer_buffer);
    chk("bf", 8'h01, 8'(buffer_full_flag));
    chk("receive_enable_bit", 8'h00, 8'(receive_enable_bit));
    pulse(write_collision_flag_clear);
    chk("write_collision_flag", 8'h00, 8'(write_collision_flag));
    sequence_busy = 1'b1;
    pulse(receive_enable_set);
    chk("receive_enable_bit", 8'h00, 8'(receive_enable_bit));
    wr(8'h99);
    chk("write_collision_flag", 8'h01, 8'(write_collision_flag));
    chk("buf", 8'hc3, transfer_buffer);
    repeat (20) @(negedge core_clk);
    sequence_busy = 1'b0;
    pulse(write_collision_flag_clear);
    s_tx = 8'h3c;
    pulse(s_start);
    pulse(receive_enable_set);
    wait_irq();
    chk("rx", 8'h3c, transfer_buffer);
    chk("ovf", 8'h01, 8'(receive_overflow_flag));
    pulse(buf_rd);
    chk("bf", 8'h00, 8'(buffer_full_flag));
    pulse(overflow_clear);
    chk("ovf", 8'h00, 8'(receive_overflow_flag));
    $display("test receive done");
    // Stop condition run by the neighbour
    sequence_busy = 1'b1;
    repeat (10) @(negedge core_clk);
    pulse(condition_done);
    sequence_busy = 1'b0;
    chk("irq", 8'h01, 8'(port_interrupt_flag));
    chk("busy", 8'h00, 8'(engine_busy));
    $display("test stop done");
    summarize();
  end
endmodule
bind ibt_byte_engine ibt_checker u_chk (.core_clk, .resetn, .buf_wr,
  .buf_wr_data, .buf_rd, .receive_enable_set, .baud_reload_register,
  .sequence_busy, .condition_done, .transfer_buffer, .buffer_full_flag,
  .write_collision_flag, .receive_overflow_flag, .port_interrupt_flag,
  .receive_enable_bit, .serial_clock_line_in, .serial_clock_line_out,
  .serial_clock_line_oe, .serial_data_line_out, .serial_data_line_oe);
